// ==== design/strap_led_pkg.sv ====
// shared constants and types for the address strap / status led pins
//
// How it works
// R01 - in hardware reset every strap pin is an input, sampled at reset exit
// R02 - after sampling, every strap pin is driven as an led output
// R03 - software reset neither resamples straps nor changes pin direction
// R04 - every strap pin stays driven as an output during software reset
// R05 - led asserted level is inverse of sampled strap, deasserted equals it
// R06 - low strap gives address bit zero, high strap gives address bit one
// R07 - address bit 0 pin shows transmit or receive activity
// R08 - address bit 1 pin shows collision, held about 70 ms per collision
// R09 - address bit 2 pin shows valid link
// R10 - board pulls each pin up or down, optionally through an led
// R11 - address bit 3 pin shows transmit activity
// R12 - address bit 4 pin shows receive activity
// R13 - address kept until hardware reset; each collision restarts the hold
package strap_led_pkg;

   // -------------------------------------------------------------
   // clock and timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned COLL_HOLD_MS = 70;
   localparam int unsigned COLL_HOLD_CYCLES = (CLK_HZ / 1000) * COLL_HOLD_MS;
   localparam int unsigned HOLD_W = 21;

   // -------------------------------------------------------------
   // pin positions in the address word
   // -------------------------------------------------------------
   localparam int unsigned NUM_PINS = 5;
   localparam int unsigned ACT_BIT = 0;
   localparam int unsigned COL_BIT = 1;
   localparam int unsigned LINK_BIT = 2;
   localparam int unsigned TXA_BIT = 3;
   localparam int unsigned RXA_BIT = 4;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [NUM_PINS-1:0] ADDR_RESET = 5'h00;
   localparam logic [NUM_PINS-1:0] LED_RESET = 5'h00;
   localparam logic [NUM_PINS-1:0] OE_ALL = 5'h1f;

   // status from the detectors that feed the leds
   typedef struct packed {
      logic tx_active;
      logic rx_active;
      logic collision;
      logic link_up;
   } status_t;

endpackage

// ==== design/pulse_stretch.sv ====
// retriggerable stretcher: holds active for a fixed count after each start
`timescale 1ns/100ps
`default_nettype none

module pulse_stretch #(
   parameter int unsigned WIDTH = 21,
   parameter logic [WIDTH-1:0] HOLD = 21'h1a_b3f0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic clear,
   input wire logic start,
   // result
   output logic active
);

   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] age_q;

   // -------------------------------------------------------------
   // hold counter
   // -------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (clear) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= HOLD; // see R13
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign active = (cnt_q != '0);

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   // cycles since the last start, saturating; read only by checks
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         age_q <= '1;
      end else if (start) begin
         age_q <= '0;
      end else if (age_q != '1) begin
         age_q <= age_q + 1'b1;
      end
   end

   a_hold_start: assert property ( // see R08
      @(posedge clk) disable iff (reset)
      start && !clear |=> active)
      else $error("stretch not active after start");

   a_hold_length: assert property ( // see R13
      @(posedge clk) disable iff (reset)
      $fell(active) && !$past(clear) |-> age_q == HOLD)
      else $error("stretch ended at wrong length");

endmodule // pulse_stretch

`default_nettype wire

// ==== design/phy_address_strap_led_pins.sv ====
// five strap pins sampled as the management address, then driven as leds
`timescale 1ns/100ps
`default_nettype none

module phy_address_strap_led_pins #(
   parameter int unsigned COLL_HOLD_CYCLES = strap_led_pkg::COLL_HOLD_CYCLES
) (
   // clock and hardware reset
   input wire logic clk,
   input wire logic reset,
   // software reset from the management side
   input wire logic sw_reset,
   // status from the link detectors
   input wire strap_led_pkg::status_t status,
   // sampled address
   output logic [4:0] phy_addr,
   output logic strap_valid,
   // address bit 0 / activity pin
   input wire logic addr0_activity_led_pin_in,
   output logic addr0_activity_led_pin_out,
   output logic addr0_activity_led_pin_oe,
   // address bit 1 / collision pin
   input wire logic addr1_collision_led_pin_in,
   output logic addr1_collision_led_pin_out,
   output logic addr1_collision_led_pin_oe,
   // address bit 2 / link pin
   input wire logic addr2_link_led_pin_in,
   output logic addr2_link_led_pin_out,
   output logic addr2_link_led_pin_oe,
   // address bit 3 / transmit activity pin
   input wire logic addr3_tx_activity_led_pin_in,
   output logic addr3_tx_activity_led_pin_out,
   output logic addr3_tx_activity_led_pin_oe,
   // address bit 4 / receive activity pin
   input wire logic addr4_rx_activity_led_pin_in,
   output logic addr4_rx_activity_led_pin_out,
   output logic addr4_rx_activity_led_pin_oe
);

   localparam int unsigned HW = strap_led_pkg::HOLD_W;
   localparam logic [HW-1:0] HOLD_C = COLL_HOLD_CYCLES[HW-1:0];

   logic [4:0] pin_in_w;
   logic [4:0] led_on_w;
   logic [4:0] led_out_q;
   logic [4:0] addr_q;
   logic captured_q;
   logic col_start_w;
   logic col_hold_w;

   // -------------------------------------------------------------
   // gather pin levels
   // -------------------------------------------------------------
   assign pin_in_w = {addr4_rx_activity_led_pin_in,
                      addr3_tx_activity_led_pin_in,
                      addr2_link_led_pin_in,
                      addr1_collision_led_pin_in,
                      addr0_activity_led_pin_in};

   // -------------------------------------------------------------
   // strap capture
   // -------------------------------------------------------------
   // pins stay inputs until the first edge after hardware reset ends;
   // that edge samples them, so the pull level is read undriven
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         captured_q <= 1'b0; // see R01
      end else begin
         captured_q <= 1'b1; // see R02
      end
   end

   // only hardware reset clears this; software reset is ignored here
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addr_q <= strap_led_pkg::ADDR_RESET;
      end else if (!captured_q) begin
         addr_q <= pin_in_w; // see R01 see R06 see R13
      end
   end

   assign phy_addr = addr_q; // see R06
   assign strap_valid = captured_q;

   // -------------------------------------------------------------
   // collision stretch
   // -------------------------------------------------------------
   // collision held high keeps retriggering, so the hold runs from its end
   assign col_start_w = status.collision && captured_q;

   pulse_stretch #(
      .WIDTH(HW),
      .HOLD(HOLD_C)
   ) u_col_stretch (
      .clk(clk),
      .reset(reset),
      .clear(sw_reset),
      .start(col_start_w), // see R08 see R13
      .active(col_hold_w)
   );

   // -------------------------------------------------------------
   // led status
   // -------------------------------------------------------------
   // software reset shows every led deasserted while still driving it
   always_comb begin
      led_on_w = 5'h00;
      if (!sw_reset) begin
         led_on_w[strap_led_pkg::ACT_BIT] =
            status.tx_active | status.rx_active; // see R07
         led_on_w[strap_led_pkg::COL_BIT] = col_hold_w; // see R08
         led_on_w[strap_led_pkg::LINK_BIT] = status.link_up; // see R09
         led_on_w[strap_led_pkg::TXA_BIT] = status.tx_active; // see R11
         led_on_w[strap_led_pkg::RXA_BIT] = status.rx_active; // see R12
      end
   end

   // on the capture edge the output starts at the deasserted level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         led_out_q <= strap_led_pkg::LED_RESET;
      end else if (!captured_q) begin
         led_out_q <= pin_in_w; // see R05
      end else begin
         led_out_q <= addr_q ^ led_on_w; // see R05
      end
   end

   // -------------------------------------------------------------
   // pin drivers
   // -------------------------------------------------------------
   // direction depends on capture only, never on software reset
   assign addr0_activity_led_pin_oe = captured_q; // see R02 see R03 see R04
   assign addr1_collision_led_pin_oe = captured_q; // see R02 see R04
   assign addr2_link_led_pin_oe = captured_q; // see R02 see R04
   assign addr3_tx_activity_led_pin_oe = captured_q; // see R02 see R04
   assign addr4_rx_activity_led_pin_oe = captured_q; // see R02 see R04

   assign addr0_activity_led_pin_out = led_out_q[strap_led_pkg::ACT_BIT];
   assign addr1_collision_led_pin_out = led_out_q[strap_led_pkg::COL_BIT];
   assign addr2_link_led_pin_out = led_out_q[strap_led_pkg::LINK_BIT];
   assign addr3_tx_activity_led_pin_out = led_out_q[strap_led_pkg::TXA_BIT];
   assign addr4_rx_activity_led_pin_out = led_out_q[strap_led_pkg::RXA_BIT];

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_input_in_reset: assert property ( // see R01
      @(posedge clk) disable iff (reset)
      !strap_valid |-> !addr0_activity_led_pin_oe
         && !addr2_link_led_pin_oe && !addr4_rx_activity_led_pin_oe)
      else $error("strap pin driven before capture");

   a_strap_sample: assert property ( // see R06
      @(posedge clk) disable iff (reset)
      $rose(strap_valid) |-> phy_addr == $past(pin_in_w))
      else $error("address differs from sampled straps");

   a_output_after: assert property ( // see R02
      @(posedge clk) disable iff (reset)
      strap_valid |=> strap_valid && addr1_collision_led_pin_oe
         && addr3_tx_activity_led_pin_oe)
      else $error("strap pin not driven after capture");

   a_addr_held: assert property ( // see R03
      @(posedge clk) disable iff (reset)
      strap_valid && $past(strap_valid) |-> $stable(phy_addr))
      else $error("address changed after capture");

   a_sw_reset_drive: assert property ( // see R04
      @(posedge clk) disable iff (reset)
      sw_reset && strap_valid |-> ##1 addr0_activity_led_pin_oe
         && addr2_link_led_pin_oe && addr4_rx_activity_led_pin_oe)
      else $error("pin released during software reset");

   a_first_level: assert property ( // see R05
      @(posedge clk) disable iff (reset)
      $rose(strap_valid) |-> led_out_q == phy_addr)
      else $error("first driven level not the deasserted one");

   a_act_led: assert property ( // see R07
      @(posedge clk) disable iff (reset)
      strap_valid && $past(strap_valid) && !$past(sw_reset)
      |-> addr0_activity_led_pin_out == (phy_addr[0]
         ^ $past(status.tx_active | status.rx_active)))
      else $error("activity led wrong");

   a_link_led: assert property ( // see R09
      @(posedge clk) disable iff (reset)
      strap_valid && $past(strap_valid) && !$past(sw_reset)
      |-> addr2_link_led_pin_out == (phy_addr[2] ^ $past(status.link_up)))
      else $error("link led wrong");

   a_txrx_led: assert property ( // see R11
      @(posedge clk) disable iff (reset)
      strap_valid && $past(strap_valid) && !$past(sw_reset)
      |-> addr3_tx_activity_led_pin_out == (phy_addr[3]
            ^ $past(status.tx_active))
         && addr4_rx_activity_led_pin_out == (phy_addr[4]
            ^ $past(status.rx_active))) // see R12
      else $error("transmit or receive led wrong");

   a_col_led: assert property ( // see R08
      @(posedge clk) disable iff (reset)
      strap_valid && status.collision && !sw_reset
      |-> ##2 (addr1_collision_led_pin_out != phy_addr[1]
         || $past(sw_reset)))
      else $error("collision led not asserted");

   a_col_release: assert property ( // see R08
      @(posedge clk) disable iff (reset)
      strap_valid && $past(strap_valid) && !$past(col_hold_w)
      |-> addr1_collision_led_pin_out == phy_addr[1])
      else $error("collision led lit without a hold");

   a_sw_reset_dark: assert property ( // see R05
      @(posedge clk) disable iff (reset)
      strap_valid && $past(strap_valid) && $past(sw_reset)
      |-> led_out_q == phy_addr)
      else $error("led lit during software reset");

endmodule // phy_address_strap_led_pins

`default_nettype wire

// ==== bench/board_pins.sv ====
// board model: strap pull resistors with series status leds
`timescale 1ns/100ps
`default_nettype none

module board_pins (
   // strap levels set by the resistors
   input wire logic [4:0] pull,
   // device pin drive
   input wire logic [4:0] out,
   input wire logic [4:0] oe,
   // level seen on each pin and led state
   output logic [4:0] level,
   output logic [4:0] lit
);
   // an undriven pin settles to its pull level and never floats
   assign level = (oe & out) | (~oe & pull);
   // current flows through the led only against the pull
   assign lit = oe & (out ^ pull);
endmodule // board_pins

`default_nettype wire

// ==== bench/phy_address_strap_led_pins_test.sv ====
// self-checking bench for the strap / status led pins
`timescale 1ns/100ps
`default_nettype none

`define chk(got, exp) begin checks++; if ((got) !== (exp)) begin \
   bad_count++; $display("mismatch at %0t: got %h expected %h", \
   $time, got, exp); end end

module phy_address_strap_led_pins_test;
   localparam int unsigned HOLD = 20;
   logic clk;
   logic reset;
   logic sw_reset;
   strap_led_pkg::status_t status;
   logic [4:0] pull;
   wire logic [4:0] phy_addr;
   wire logic strap_valid;
   wire logic [4:0] out;
   wire logic [4:0] oe;
   wire logic [4:0] level;
   wire logic [4:0] lit;
   int bad_count;
   int checks;

   phy_address_strap_led_pins #(
      .COLL_HOLD_CYCLES(HOLD)
   ) i_phy_address_strap_led_pins (
      .clk(clk), .reset(reset), .sw_reset(sw_reset), .status(status),
      .phy_addr(phy_addr), .strap_valid(strap_valid),
      .addr0_activity_led_pin_in(level[0]),
      .addr0_activity_led_pin_out(out[0]),
      .addr0_activity_led_pin_oe(oe[0]),
      .addr1_collision_led_pin_in(level[1]),
      .addr1_collision_led_pin_out(out[1]),
      .addr1_collision_led_pin_oe(oe[1]),
      .addr2_link_led_pin_in(level[2]), .addr2_link_led_pin_out(out[2]),
      .addr2_link_led_pin_oe(oe[2]),
      .addr3_tx_activity_led_pin_in(level[3]),
      .addr3_tx_activity_led_pin_out(out[3]),
      .addr3_tx_activity_led_pin_oe(oe[3]),
      .addr4_rx_activity_led_pin_in(level[4]),
      .addr4_rx_activity_led_pin_out(out[4]),
      .addr4_rx_activity_led_pin_oe(oe[4]));

   board_pins i_board_pins (
      .pull(pull), .out(out), .oe(oe), .level(level), .lit(lit));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic hw_reset(logic [4:0] strap);
      @(posedge clk);
      reset <= 1'b1;
      status <= '0;
      pull <= strap;
      tick(11);
      #1 `chk(oe, 5'h00)
      `chk(strap_valid, 1'b0)
      @(posedge clk) reset <= 1'b0;
      tick(1);
      #1 `chk(phy_addr, strap)
      `chk(strap_valid, 1'b1)
      `chk(oe, 5'h1f)
      `chk(out, strap)
   endtask

   task automatic t_leds();
      logic [4:0] on;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) status <= {i[0], i[1], 1'b0, i[2]};
         on = {i[1], i[0], i[2], 1'b0, i[0] | i[1]};
         tick(2);
         #1 `chk(out, pull ^ on)
         `chk(lit, on)
      end
   endtask

   task automatic pulse_coll();
      @(posedge clk) status.collision <= 1'b1;
      @(posedge clk) status.collision <= 1'b0;
   endtask

   task automatic t_coll();
      pulse_coll();
      tick(1);
      #1 `chk(out[1], ~pull[1])
      tick(7);
      pulse_coll();
      tick(HOLD);
      #1 `chk(out[1], ~pull[1])
      tick(2);
      #1 `chk(out[1], pull[1])
   endtask

   task automatic t_sw();
      @(posedge clk) status.link_up <= 1'b1;
      pulse_coll();
      @(posedge clk) sw_reset <= 1'b1;
      tick(3);
      #1 `chk(oe, 5'h1f)
      `chk(out, pull)
      `chk(phy_addr, pull)
      `chk(strap_valid, 1'b1)
      @(posedge clk) sw_reset <= 1'b0;
      tick(2);
      #1 `chk(out[2], ~pull[2])
      `chk(out[1], pull[1])
   endtask

   initial begin
      #120000;
      bad_count++;
      complete_run();
   end

   initial begin
      reset = 1'b1;
      sw_reset = 1'b0;
      status = '0;
      pull = 5'h15;
      bad_count = 0;
      checks = 0;
      hw_reset(5'h15);
      t_leds();
      t_coll();
      t_sw();
      hw_reset(5'h0a);
      t_leds();
      complete_run();
   end
endmodule // phy_address_strap_led_pins_test

`default_nettype wire
